// [rtl/dpi_consts.vh]
// Constants for the memory power-up sequencing controller
`ifndef DPI_CONSTS_VH
`define DPI_CONSTS_VH

// Wishbone register byte addresses
`define DPI_ADDR_CTRL       4'h0
`define DPI_ADDR_STATUS     4'h4
`define DPI_ADDR_MODE       4'h8
`define DPI_ADDR_MRDATA     4'hC

// Control register fields
`define DPI_CTRL_START      0
`define DPI_CTRL_WARM       1
`define DPI_CTRL_NOREPAIR   2
`define DPI_CTRL_NEXT       3

// Mode register addresses on the command bus
`define DPI_MA_INFO         6'h00
`define DPI_MA_LAT          6'h02
`define DPI_MA_IOCFG        6'h03
`define DPI_MA_MAKER        6'h05
`define DPI_MA_REV          6'h06
`define DPI_MA_WIDTH        6'h08
`define DPI_MA_REGCTL       6'h0D
`define DPI_MA_REPAIR       6'h19

// Mode register values
`define DPI_LAT_DEFAULT     8'h00
`define DPI_LAT_WRLEV       8'h80
`define DPI_IOCFG_PROTECT   8'h04
`define DPI_IOCFG_PLAIN     8'h00
`define DPI_REGCTL_DEFAULT  8'h00
`define DPI_REGCTL_CBT      8'h01

// Command opcodes, first half of a two-tick word
`define DPI_OP_MRW1         6'h06
`define DPI_OP_MRW2         6'h16
`define DPI_OP_MRR          6'h0E
`define DPI_OP_MPC          6'h00
// Multipurpose opcodes are 7 bits wide
`define DPI_MPC_CALBEGIN    7'h4F
`define DPI_MPC_CALAPPLY    7'h51
`define DPI_MPC_RDCAL       7'h43

// Timing, printed figures and derived cycle counts at 100 MHz
`define DPI_CLK_NS          10
`define DPI_RESET_HOLD_US   200
`define DPI_CKE_BEFORE_NS   10
`define DPI_CKE_AFTER_MS    2
`define DPI_STABLE_CLOCKS   5
`define DPI_FIRST_MODE_US   2
`define DPI_WARM_PULSE_NS   100
`define DPI_CAL_TIME_NS     1000
`define DPI_LATCH_TIME_NS   30
`define DPI_RESET_HOLD_CYC  ((`DPI_RESET_HOLD_US*1000+`DPI_CLK_NS-1)/`DPI_CLK_NS)
`define DPI_CKE_BEFORE_CYC  ((`DPI_CKE_BEFORE_NS+`DPI_CLK_NS-1)/`DPI_CLK_NS)
`define DPI_CKE_AFTER_CYC   ((`DPI_CKE_AFTER_MS*1000000+`DPI_CLK_NS-1)/`DPI_CLK_NS)
`define DPI_FIRST_MODE_CYC  ((`DPI_FIRST_MODE_US*1000+`DPI_CLK_NS-1)/`DPI_CLK_NS)
`define DPI_WARM_PULSE_CYC  ((`DPI_WARM_PULSE_NS+`DPI_CLK_NS-1)/`DPI_CLK_NS)
`define DPI_CAL_TIME_CYC    ((`DPI_CAL_TIME_NS+`DPI_CLK_NS-1)/`DPI_CLK_NS)
`define DPI_LATCH_TIME_CYC  ((`DPI_LATCH_TIME_NS+`DPI_CLK_NS-1)/`DPI_CLK_NS)

`endif

// [rtl/dpi_init_ctrl.v]
// Power-up and initialization sequencer for a low-power DRAM channel
// Behaviour
// - Each command word is two 6-bit halves on consecutive rising edges.
// - Read, write, masked write, activate need two back-to-back two-tick words.
// - Activate opens bank and row; read or write then picks bank and column.
// - All channels run the power-up sequence together, never one by one.
// - Hold reset low at least 200 us once supplies are stable.
// - Drive clock enable low at least 10 ns before releasing reset.
// - Keep clock enable low at least 2 ms after reset release.
// - Five stable clocks before clock enable; chip select low meanwhile.
// - Wait 2 us after clock enable before any mode register access.
// - Boot mode accesses use a clock within the boot cycle-time range.
// - Start calibration after mode writes; never overlap shared calibrations.
// - After calibration time issue the apply command to latch values.
// - After latch wait train the command bus via a mode write.
// - Then perform write leveling by setting the latency register bit 7.
// - Then train the data bus with calibration reads, array untouched.
// - Warm reset: reset low at least 100 ns, then repeat from clock wait.
// - Without repair use, set the repair-protection bit to one.
`timescale 1ns/10ps
`include "dpi_consts.vh"

module dpi_init_ctrl #(
   parameter RESET_HOLD_CYC = `DPI_RESET_HOLD_CYC,
   parameter CKE_AFTER_CYC  = `DPI_CKE_AFTER_CYC
) (
   input  wire        clock,       // System clock, 100 MHz
   input  wire        reset,       // Async reset, active high
   input  wire [3:0]  wb_adr_i,    // Wishbone byte address
   input  wire [31:0] wb_dat_i,    // Wishbone write data
   input  wire [3:0]  wb_sel_i,    // Wishbone byte selects
   input  wire        wb_we_i,     // Wishbone write enable
   input  wire        wb_cyc_i,    // Wishbone cycle
   input  wire        wb_stb_i,    // Wishbone strobe
   output reg  [31:0] wb_dat_o,    // Wishbone read data
   output reg         wb_ack_o,    // Wishbone acknowledge
   output reg         memResetN,   // Memory reset, active low
   output reg         memCke,      // Memory clock enable
   output reg         memCs,       // Memory chip select
   output reg  [5:0]  commandBus,  // Two-tick command bus
   input  wire [7:0]  dqIn,        // Data bus low byte from memory
   output reg  [7:0]  dqOut,       // Data bus drive value
   output reg         dqOe         // Data bus output enable
);

   localparam [12:0] S_IDLE   = 13'h0001;
   localparam [12:0] S_RSTLOW = 13'h0002;
   localparam [12:0] S_CKEOFF = 13'h0004;
   localparam [12:0] S_CKEWT  = 13'h0008;
   localparam [12:0] S_CLKWT  = 13'h0010;
   localparam [12:0] S_MODEWT = 13'h0020;
   localparam [12:0] S_CMD    = 13'h0040;
   localparam [12:0] S_WAIT   = 13'h0080;
   localparam [12:0] S_SWTRN  = 13'h0100;
   localparam [12:0] S_READY  = 13'h0200;
   localparam [12:0] S_RDWT   = 13'h0400;
   localparam [12:0] S_WARM   = 13'h0800;
   localparam [12:0] S_RDCAP  = 13'h1000;

   // Waits trimmed to the counter width
   localparam [20:0] CKE_BEFORE_C = `DPI_CKE_BEFORE_CYC;
   localparam [20:0] CKE_STABLE_C = `DPI_STABLE_CLOCKS;
   localparam [20:0] FIRST_MODE_C = `DPI_FIRST_MODE_CYC;
   localparam [20:0] WARM_PULSE_C = `DPI_WARM_PULSE_CYC;
   localparam [20:0] CAL_TIME_C   = `DPI_CAL_TIME_CYC;
   localparam [20:0] LATCH_TIME_C = `DPI_LATCH_TIME_CYC;
   localparam [5:0]  OP_MRW1      = `DPI_OP_MRW1;
   localparam [5:0]  OP_MRW2      = `DPI_OP_MRW2;
   localparam [5:0]  OP_MPC       = `DPI_OP_MPC;

   // Mode write: value bits 7 and 6 ride in bit 5 of the first halves
   function [23:0] mrwWord;
      input [5:0] ma;
      input [7:0] val;
      mrwWord = {val[7], OP_MRW1[4:0], ma, val[6], OP_MRW2[4:0],
                 val[5:0]};
   endfunction
   // Opcode bit 6 rides in bit 5 of the first half
   function [23:0] mpcWord;
      input [6:0] op;
      mpcWord = {op[6], OP_MPC[4:0], op[5:0], 12'h000};
   endfunction

   reg [12:0] state_ff;
   reg [12:0] nxt_state;
   reg [3:0]  step_ff;
   reg [3:0]  nxt_step;
   reg [1:0]  tick_ff;
   reg [1:0]  nxt_tick;
   reg [20:0] count_ff;
   reg [20:0] nxt_count;
   reg        noRepair_ff;
   reg        warm_ff;
   reg [7:0]  repair_ff;
   reg [7:0]  info_ff;
   reg        busy_ff;
   reg        nxtPulse_ff;
   reg [7:0]  nxt_dqOut;
   reg        nxt_memResetN;
   reg        nxt_memCke;
   reg        nxt_memCs;
   reg [5:0]  nxt_commandBus;
   reg        stepDone;
   reg [23:0] word;
   reg [20:0] waitAfter;
   reg        isRead;
   reg        phaseWait;

   wire busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   wire busRead  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   wire startReq = busWrite & wb_sel_i[0] & (wb_adr_i == `DPI_ADDR_CTRL)
                   & wb_dat_i[`DPI_CTRL_START];
   wire warmReq  = busWrite & wb_sel_i[0] & (wb_adr_i == `DPI_ADDR_CTRL)
                   & wb_dat_i[`DPI_CTRL_WARM];
   wire nextReq  = busWrite & wb_sel_i[0] & (wb_adr_i == `DPI_ADDR_CTRL)
                   & wb_dat_i[`DPI_CTRL_NEXT];

   // Sequence table: two two-tick words (four halves) and the wait after them
   always @* begin
      word      = 24'h000000;
      waitAfter = 21'd1;
      isRead    = 1'b0;
      case (step_ff)
         4'd0: word = mrwWord(`DPI_MA_IOCFG, noRepair_ff ?
                              `DPI_IOCFG_PROTECT : `DPI_IOCFG_PLAIN);
         4'd1: word = mrwWord(`DPI_MA_LAT, `DPI_LAT_DEFAULT);
         // calibration begin, one device at a time
         4'd2: begin
            word      = mpcWord(`DPI_MPC_CALBEGIN);
            waitAfter = CAL_TIME_C;
         end
         4'd3: begin
            word      = mpcWord(`DPI_MPC_CALAPPLY);
            waitAfter = LATCH_TIME_C;
         end
         4'd4: word = mrwWord(`DPI_MA_REGCTL, `DPI_REGCTL_CBT);
         // training exit, set point 0 restored
         4'd5: word = mrwWord(`DPI_MA_REGCTL, `DPI_REGCTL_DEFAULT);
         // write leveling entry by bit 7
         4'd6: word = mrwWord(`DPI_MA_LAT, `DPI_LAT_WRLEV);
         4'd7: word = mrwWord(`DPI_MA_LAT, `DPI_LAT_DEFAULT);
         4'd8: word = mpcWord(`DPI_MPC_RDCAL);
         4'd9: begin
            word   = {`DPI_OP_MRR, `DPI_MA_REPAIR, 12'h000};
            isRead = 1'b1;
         end
         4'd10: begin
            word   = {`DPI_OP_MRR, `DPI_MA_INFO, 12'h000};
            isRead = 1'b1;
         end
         default: word = 24'h000000;
      endcase
   end

   always @* begin
      nxt_state      = state_ff;
      nxt_step       = step_ff;
      nxt_tick       = tick_ff;
      nxt_count      = count_ff;
      nxt_memResetN  = memResetN;
      nxt_memCke     = memCke;
      nxt_memCs      = 1'b0;
      nxt_commandBus = 6'h00;
      nxt_dqOut      = 8'h00;
      stepDone       = 1'b0;
      phaseWait      = 1'b0;
      // every timed wait is a down counter
      if (count_ff != 21'd0)
         nxt_count = count_ff - 21'd1;
      case (state_ff)
         S_IDLE: begin
            if (startReq) begin
               // clock enable and reset drop together before anything else
               nxt_memCke    = 1'b0;
               nxt_memResetN = 1'b0;
               nxt_count     = RESET_HOLD_CYC[20:0];
               nxt_state     = S_RSTLOW;
            end
         end
         S_WARM: begin
            if (count_ff == 21'd0) begin
               nxt_count = CKE_BEFORE_C;
               nxt_state = S_CKEOFF;
            end
         end
         S_RSTLOW: begin
            if (count_ff == 21'd0) begin
               nxt_count = CKE_BEFORE_C;
               nxt_state = S_CKEOFF;
            end
         end
         S_CKEOFF: begin
            // one pin set releases every channel at once
            if (count_ff == 21'd0) begin
               nxt_memResetN = 1'b1;
               nxt_count     = CKE_AFTER_CYC[20:0];
               nxt_state     = S_CKEWT;
            end
         end
         S_CKEWT: begin
            // clock enable held low after release
            if (count_ff == 21'd0) begin
               nxt_count = CKE_STABLE_C;
               nxt_state = S_CLKWT;
            end
         end
         S_CLKWT: begin
            if (count_ff == 21'd0) begin
               nxt_memCke = 1'b1;
               nxt_count  = FIRST_MODE_C;
               nxt_state  = S_MODEWT;
            end
         end
         S_MODEWT: begin
            if (count_ff == 21'd0) begin
               nxt_step  = 4'd0;
               nxt_tick  = 2'd0;
               nxt_state = S_CMD;
            end
         end
         S_CMD: begin
            // boot commands run on the system clock
            // one half per edge, both words back to back
            nxt_memCs = (tick_ff == 2'd0) || (tick_ff == 2'd2);
            case (tick_ff)
               2'd0: nxt_commandBus = word[23:18];
               2'd1: nxt_commandBus = word[17:12];
               2'd2: nxt_commandBus = word[11:6];
               default: nxt_commandBus = word[5:0];
            endcase
            nxt_tick = tick_ff + 2'd1;
            if (tick_ff == 2'd3) begin
               nxt_count = waitAfter;
               nxt_state = isRead ? S_RDWT : S_WAIT;
            end
         end
         S_RDWT: begin
            if (count_ff == 21'd0)
               nxt_state = S_RDCAP;
         end
         S_RDCAP: begin
            stepDone  = 1'b1;
            nxt_state = S_WAIT;
         end
         S_WAIT: begin
            if (count_ff == 21'd0) begin
               phaseWait = (step_ff == 4'd6);
               if (phaseWait)
                  nxt_state = S_SWTRN;
               else if (step_ff == 4'd10)
                  nxt_state = S_READY;
               else begin
                  nxt_step  = step_ff + 4'd1;
                  nxt_state = S_CMD;
               end
            end
         end
         S_SWTRN: begin
            // Leveling delay search is software's; it says when done
            if (nxtPulse_ff) begin
               nxt_step  = step_ff + 4'd1;
               nxt_state = S_CMD;
            end
         end
         S_READY: begin
            // row and column accesses belong to the main scheduler
            if (startReq) begin
               nxt_memCke    = 1'b0;
               nxt_memResetN = 1'b0;
               nxt_count     = RESET_HOLD_CYC[20:0];
               nxt_state     = S_RSTLOW;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
      // warm reset from any state, clock enable and reset drop in the same cycle
      if (warmReq) begin
         nxt_memCke    = 1'b0;
         nxt_memResetN = 1'b0;
         nxt_count     = WARM_PULSE_C;
         nxt_state     = S_WARM;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff    <= S_IDLE;
         step_ff     <= 4'd0;
         tick_ff     <= 2'd0;
         count_ff    <= 21'd0;
         memResetN   <= 1'b0;
         memCke      <= 1'b0;
         memCs       <= 1'b0;
         commandBus  <= 6'h00;
         dqOut       <= 8'h00;
         dqOe        <= 1'b0;
         noRepair_ff <= 1'b1;
         warm_ff     <= 1'b0;
         repair_ff   <= 8'h00;
         info_ff     <= 8'h00;
         busy_ff     <= 1'b0;
         nxtPulse_ff <= 1'b0;
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= 32'h00000000;
      end else begin
         state_ff    <= nxt_state;
         step_ff     <= nxt_step;
         tick_ff     <= nxt_tick;
         count_ff    <= nxt_count;
         memResetN   <= nxt_memResetN;
         memCke      <= nxt_memCke;
         memCs       <= nxt_memCs;
         commandBus  <= nxt_commandBus;
         dqOut       <= nxt_dqOut;
         // Never drive the data bus during boot; the device answers on it
         dqOe        <= 1'b0;
         busy_ff     <= (nxt_state != S_IDLE) && (nxt_state != S_READY);
         nxtPulse_ff <= nextReq;
         if (warmReq)
            warm_ff <= 1'b1;
         else if (startReq)
            warm_ff <= 1'b0;
         if (busWrite && wb_sel_i[0] && (wb_adr_i == `DPI_ADDR_CTRL))
            noRepair_ff <= wb_dat_i[`DPI_CTRL_NOREPAIR];
         // captured read answers: repair banks, one bit per bank, then device info
         if (stepDone && (step_ff == 4'd9))
            repair_ff <= dqIn;
         if (stepDone && (step_ff == 4'd10))
            info_ff <= dqIn;
         wb_ack_o <= (busWrite | busRead);
         case (wb_adr_i)
            `DPI_ADDR_CTRL:   wb_dat_o <= {29'h0, noRepair_ff, warm_ff, 1'b0};
            `DPI_ADDR_STATUS: wb_dat_o <= {15'h0, state_ff, 2'h0, busy_ff,
                                           state_ff == S_READY};
            `DPI_ADDR_MODE:   wb_dat_o <= {24'h0, info_ff};
            `DPI_ADDR_MRDATA: wb_dat_o <= {24'h0, repair_ff};
            default:          wb_dat_o <= 32'h00000000;
         endcase
      end
   end

endmodule // dpi_init_ctrl

// [bench/dpi_init_properties.sv]
// Pin timing checks for the power-up sequencer
`timescale 1ns/10ps
module dpi_init_props #(
   parameter RESET_HOLD_CYC = 20000,
   parameter CKE_AFTER_CYC  = 200000
) (
   input wire clock,     // Clock
   input wire reset,     // Async reset
   input wire wb_cyc_i,  // Bus cycle
   input wire wb_stb_i,  // Bus strobe
   input wire wb_ack_o,  // Bus ack
   input wire memResetN, // Memory reset, low
   input wire memCke,    // Clock enable
   input wire memCs,     // Chip select
   input wire dqOe       // Data drive enable
);
   localparam WARM_CYC  = 10;
   localparam FIRST_CYC = 200;
   reg [31:0] lowCnt_ff;
   reg [31:0] ckeWait_ff;
   reg [31:0] ckeHi_ff;
   reg        coldDone_ff;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Cycles spent in each phase, cleared on leaving it
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         lowCnt_ff   <= 32'h0;
         ckeWait_ff  <= 32'h0;
         ckeHi_ff    <= 32'h0;
         coldDone_ff <= 1'b0;
      end else begin
         lowCnt_ff   <= memResetN ? 32'h0 : lowCnt_ff + 32'h1;
         ckeWait_ff  <= (memResetN && !memCke) ? ckeWait_ff + 32'h1 : 32'h0;
         ckeHi_ff    <= memCke ? ckeHi_ff + 32'h1 : 32'h0;
         coldDone_ff <= coldDone_ff | memResetN;
      end
   end
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("no ack one cycle after request");
   AST_COLD_HOLD: assert property (
      $rose(memResetN) && !coldDone_ff |-> lowCnt_ff >= RESET_HOLD_CYC)
      else $error("cold reset released early");
   AST_WARM_HOLD: assert property (
      $rose(memResetN) |-> lowCnt_ff >= WARM_CYC)
      else $error("reset pulse too short");
   AST_CKE_BEFORE: assert property (
      $rose(memResetN) |-> !memCke && !$past(memCke))
      else $error("enable not low before release");
   AST_CKE_WAIT: assert property (
      $rose(memCke) |-> ckeWait_ff >= CKE_AFTER_CYC)
      else $error("enable raised too soon");
   AST_CKE_IN_RESET: assert property (!memResetN |-> !memCke)
      else $error("enable high during reset");
   AST_CS_AT_CKE: assert property ($rose(memCke) |-> !memCs)
      else $error("select high as enable rises");
   AST_MODE_WAIT: assert property (memCs |-> ckeHi_ff >= FIRST_CYC)
      else $error("command too soon after enable");
   AST_TWO_TICK: assert property (memCs |=> !memCs)
      else $error("select on second half");
   AST_DQ_RELEASED: assert property (!dqOe)
      else $error("controller drives data");
endmodule // dpi_init_props

bind dpi_init_ctrl dpi_init_props #(
   .RESET_HOLD_CYC(RESET_HOLD_CYC),
   .CKE_AFTER_CYC(CKE_AFTER_CYC)
) props_u (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .memResetN(memResetN),
   .memCke(memCke), .memCs(memCs), .dqOe(dqOe));

// [bench/dpi_mem_model.sv]
// Behavioural memory channel seen by the sequencer
`timescale 1ns/10ps
module dpi_mem_model #(
   parameter [7:0] INFO_VAL   = 8'h12, // Device info bits
   parameter [7:0] MAKER_VAL  = 8'h3C, // Arbitrary maker code
   parameter [7:0] REPAIR_VAL = 8'hA5  // Free repair banks
) (
   input  wire       clock,      // Clock
   input  wire       memResetN,  // Reset, active low
   input  wire       memCs,      // Chip select
   input  wire [5:0] commandBus, // Command halves
   output wire [7:0] dqIn,       // Data toward controller
   output wire [7:0] mrLat,      // Latency register
   output wire [7:0] mrIo,       // I/O config register
   output reg        cbtSeen,    // Bus training entered
   output reg        calOk,      // Begin seen before apply
   output reg        trainSeen   // Calibration read seen
);
   reg [7:0]  mr [0:31];
   reg [5:0]  half0_ff;
   reg [5:0]  ma_ff;
   reg [7:0]  rdData_ff;
   reg        second_ff;
   reg        opHi_ff;
   reg        calBegun_ff;
   reg        rdValid_ff;
   reg        tog_ff = 1'b0;
   integer    i;
   wire [6:0] mpcOp = {half0_ff[5], commandBus};
   assign mrLat = mr[2];
   assign mrIo  = mr[3];
   // boot reads use one lane byte; bursts are not modelled
   // outputs released
   // Released bus toggles so stale data never passes for an answer
   assign dqIn = (memResetN && rdValid_ff) ? rdData_ff : {8{tog_ff}};
   always @(posedge clock) begin
      tog_ff <= ~tog_ff;
      if (!memResetN) begin
         for (i = 0; i < 32; i = i + 1) mr[i] <= 8'h00;
         mr[0] <= INFO_VAL;
         mr[5] <= MAKER_VAL;
         mr[25] <= REPAIR_VAL;
         second_ff <= 1'b0;
         rdValid_ff <= 1'b0;
         cbtSeen <= 1'b0;
         calOk <= 1'b0;
         calBegun_ff <= 1'b0;
         trainSeen <= 1'b0;
      end else if (memCs) begin
         half0_ff <= commandBus;
         second_ff <= 1'b1;
      end else if (second_ff) begin
         second_ff <= 1'b0;
         case (half0_ff[4:0])
            5'h06: begin
               opHi_ff <= half0_ff[5];
               ma_ff <= commandBus;
            end
            5'h16: if (!ma_ff[5] && ma_ff != 6'h00 && ma_ff != 6'h05 &&
                      ma_ff != 6'h06 && ma_ff != 6'h08 && ma_ff != 6'h19) begin
               mr[ma_ff[4:0]] <= {opHi_ff, half0_ff[5], commandBus};
               if (ma_ff == 6'h0D && commandBus[0]) cbtSeen <= 1'b1;
            end
            5'h0E: begin
               rdData_ff <= mr[commandBus[4:0]];
               rdValid_ff <= 1'b1;
            end
            5'h00: begin
               if (mpcOp == 7'h4F) calBegun_ff <= 1'b1;
               if (mpcOp == 7'h51) calOk <= calBegun_ff;
               if (mpcOp == 7'h43) trainSeen <= 1'b1;
            end
            default: ;
         endcase
      end
   end
endmodule // dpi_mem_model

// [bench/dram_power_up_init_sequence_tb_top.sv]
// Self-checking bench for the power-up sequencer
`timescale 1ns/10ps
`include "dpi_consts.vh"
module dram_power_up_init_sequence_tb_top;
   localparam       HOLD   = 20;
   localparam       CKEW   = 30;
   localparam       LIMIT  = 20000;
   localparam [7:0] INFO   = 8'h12;
   localparam [7:0] REPAIR = 8'hA5;
   reg              clock, reset, wbWe, wbCyc, wbStb;
   reg  [3:0]       wbAdr, wbSel;
   reg  [31:0]      wbDat, rd;
   wire [31:0]      wbDatO;
   wire             wbAck, memResetN, memCke, memCs, dqOe;
   wire             cbtSeen, calOk, trainSeen;
   wire [5:0]       commandBus;
   wire [7:0]       dqIn, dqOut, mrLat, mrIo;
   integer          mismatches, checked, cycles;

   dpi_init_ctrl #(.RESET_HOLD_CYC(HOLD), .CKE_AFTER_CYC(CKEW)) dut_u (
      .clock(clock), .reset(reset), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
      .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .memResetN(memResetN),
      .memCke(memCke), .memCs(memCs), .commandBus(commandBus),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
   dpi_mem_model #(.INFO_VAL(INFO), .REPAIR_VAL(REPAIR)) mdl_u (
      .clock(clock), .memResetN(memResetN), .memCs(memCs),
      .commandBus(commandBus), .dqIn(dqIn), .mrLat(mrLat), .mrIo(mrIo),
      .cbtSeen(cbtSeen), .calOk(calOk), .trainSeen(trainSeen));

   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask

   // Classic cycle, held until ack is sampled
   task wbXfer(input [3:0] a, input w, input [31:0] d);
      begin
         @(posedge clock);
         wbCyc <= 1'b1;
         wbStb <= 1'b1;
         wbAdr <= a;
         wbWe <= w;
         wbDat <= d;
         @(posedge clock);
         while (wbAck !== 1'b1) @(posedge clock);
         rd = wbDatO;
         wbCyc <= 1'b0;
         wbStb <= 1'b0;
         wbWe <= 1'b0;
      end
   endtask

   task t_idle;
      begin
         wbXfer(`DPI_ADDR_STATUS, 1'b0, 32'h0);
         chk(rd[0], 1'b0);
         chk(rd[1], 1'b0);
         chk(dqOut, 8'h00);
         chk(memResetN, 1'b0);
         wbXfer(4'h2, 1'b1, 32'hFF);
         wbXfer(4'h2, 1'b0, 32'h0);
         chk(rd, 32'h0);
         chk(memResetN, 1'b0);
      end
   endtask

   // Cold start or warm reset, then the whole bring-up
   task t_boot(input [31:0] cmd);
      integer n;
      begin
         wbXfer(`DPI_ADDR_CTRL, 1'b1, cmd);
         n = 0;
         while (memResetN !== 1'b0 && n < 50) begin
            @(posedge clock);
            n = n + 1;
         end
         repeat (2) @(posedge clock);
         chk(mrLat, 8'h00);
         chk(mrIo[7:6], 2'b00);
         chk(memCke, 1'b0);
         wbXfer(`DPI_ADDR_STATUS, 1'b0, 32'h0);
         chk(rd[1], 1'b1);
         n = 0;
         while (mrLat[7] !== 1'b1 && n < 5000) begin
            @(posedge clock);
            n = n + 1;
         end
         chk(mrLat, 8'h80);
         chk(mrIo[2], 1'b1);
         chk(calOk, 1'b1);
         chk(cbtSeen, 1'b1);
         wbXfer(`DPI_ADDR_CTRL, 1'b1, 32'hC);
         rd = 32'h0;
         n = 0;
         while (rd[0] !== 1'b1 && n < 500) begin
            wbXfer(`DPI_ADDR_STATUS, 1'b0, 32'h0);
            n = n + 1;
         end
         chk(rd[0], 1'b1);
         chk(rd[1], 1'b0);
         chk(trainSeen, 1'b1);
         wbXfer(`DPI_ADDR_MRDATA, 1'b0, 32'h0);
         chk(rd, {24'h0, REPAIR});
         wbXfer(`DPI_ADDR_MODE, 1'b0, 32'h0);
         chk(rd, {24'h0, INFO});
      end
   endtask

   task print_verdict;
      begin
         if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches = mismatches + 1;
         print_verdict;
      end
   end

   initial begin
      mismatches = 0;
      checked = 0;
      cycles = 0;
      reset = 1'b1;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 4'h0;
      wbSel = 4'hF;
      wbDat = 32'h0;
      rd = 32'h0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      t_idle;
      t_boot(32'h5);
      t_boot(32'h6);
      print_verdict;
   end
endmodule // dram_power_up_init_sequence_tb_top
